// file: sim/rcs_far_side.sv
// Model of the reset pin, supply monitor and watchdog around the sequencer
`timescale 1ns/1ps

module rcs_far_side (
  input  wire clk,
  output reg  extRstNPin,
  output reg  lowSupplyRaw,
  output reg  wdtOverflow
);
  // ==========
  // Idle levels: pin pulled high, supply good, no overflow
  initial begin
    extRstNPin   = 1'b1;
    lowSupplyRaw = 1'b0;
    wdtOverflow  = 1'b0;
  end

  task pinLow(input integer n);
    @(posedge clk);
    extRstNPin <= 1'b0;
    repeat (n) @(posedge clk);
    extRstNPin <= 1'b1;
  endtask

  task supplyLow(input integer n);
    @(posedge clk);
    lowSupplyRaw <= 1'b1;
    repeat (n) @(posedge clk);
    lowSupplyRaw <= 1'b0;
  endtask

  task wdtPulse;
    @(posedge clk);
    wdtOverflow <= 1'b1;
    @(posedge clk);
    wdtOverflow <= 1'b0;
  endtask
endmodule // rcs_far_side

// file: sim/rcs_sequencer_sva.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps

module rcs_sequencer_sva (
  input wire       clk,
  input wire       rst,
  input wire       lowSupplyRaw,
  input wire       wdtOverflow,
  input wire       haltExec,
  input wire       clrWdtExec,
  input wire       regRdStrobe,
  input wire [7:0] regRdData,
  input wire [7:0] portAPinOeN,
  input wire [2:0] portBPinOeN,
  input wire       coreRst,
  input wire       coreStall,
  input wire       pcLoad,
  input wire [9:0] pcInit,
  input wire       prescalerClr,
  input wire [7:0] watchdogSelect,
  input wire       timeoutFlag,
  input wire       powerdownFlag
);
  // ==========
  // One clock domain, reset disables everything
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pcinit; pcInit == 10'h000; endproperty
  a_pcinit: assert property (p_pcinit) else $error("pc init not zero");
  property p_load; coreRst |-> pcLoad && prescalerClr; endproperty
  a_load: assert property (p_load) else $error("no pc load in reset");
  property p_ports; coreRst |=> portAPinOeN == 8'hff && portBPinOeN == 3'h7;
  endproperty
  a_ports: assert property (p_ports) else $error("ports not input");
  property p_sel; coreRst |=> watchdogSelect == 8'h07; endproperty
  a_sel: assert property (p_sel) else $error("select not reloaded");
  property p_stall; coreRst |-> coreStall; endproperty
  a_stall: assert property (p_stall) else $error("reset without stall");
  property p_wdtrun; !coreStall && wdtOverflow |=> coreRst; endproperty
  a_wdtrun: assert property (p_wdtrun) else $error("no watchdog reset");
  property p_clrwdt; !coreStall && clrWdtExec && !wdtOverflow
    |=> !timeoutFlag && !powerdownFlag; endproperty
  a_clrwdt: assert property (p_clrwdt) else $error("flags not cleared");
  property p_halt; !coreStall && haltExec && !wdtOverflow && !clrWdtExec
    |=> powerdownFlag && !timeoutFlag && coreStall; endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  property p_keep; !coreStall && !wdtOverflow && !clrWdtExec && !haltExec
    && !lowSupplyRaw |=> $stable({timeoutFlag, powerdownFlag}); endproperty
  a_keep: assert property (p_keep) else $error("flags changed");
  property p_rdzero; !$past(regRdStrobe) |-> regRdData == 8'h00; endproperty
  a_rdzero: assert property (p_rdzero) else $error("read data not idle");
  property p_warm; pcLoad && !coreRst |-> coreStall && timeoutFlag
    && powerdownFlag; endproperty
  a_warm: assert property (p_warm) else $error("warm load wrong");
  property p_haltclr; !coreStall && haltExec && !wdtOverflow && !clrWdtExec
    |=> prescalerClr; endproperty
  a_haltclr: assert property (p_haltclr) else $error("halt no clear");
endmodule // rcs_sequencer_sva

bind rcs_sequencer rcs_sequencer_sva u_rcs_sequencer_sva (
  .clk(clk), .rst(rst), .lowSupplyRaw(lowSupplyRaw),
  .wdtOverflow(wdtOverflow), .haltExec(haltExec), .clrWdtExec(clrWdtExec),
  .regRdStrobe(regRdStrobe), .regRdData(regRdData),
  .portAPinOeN(portAPinOeN), .portBPinOeN(portBPinOeN), .coreRst(coreRst),
  .coreStall(coreStall), .pcLoad(pcLoad), .pcInit(pcInit),
  .prescalerClr(prescalerClr), .watchdogSelect(watchdogSelect),
  .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag)
);

// file: sim/tb.sv
// Self-checking testbench for the reset cause and start-up sequencer
`timescale 1ns/1ps
`include "rcs_regs.vh"

module tb;
  reg        clk, rst, brownoutOption, haltExec, clrWdtExec, sawRst;
  reg        regWrStrobe, regRdStrobe;
  reg  [7:0] wakeOption, regWrData, portAPinIn;
  reg  [3:0] regAddr;
  wire [7:0] regRdData, watchdogSelect, portAPinOeN;
  wire [2:0] portBPinOeN, portBPinOut;
  reg  [2:0] portBPinIn;
  wire [7:0] portAPinOut;
  wire [9:0] pcInit;
  wire       pcLoad, prescalerClr;
  wire       extRstNPin, lowSupplyRaw, wdtOverflow, coreRst, coreStall;
  wire       timeoutFlag, powerdownFlag;
  integer    numErrors, nTests, nStall;

  // ==========
  // Design and far side; low supply filter shortened to 20 cycles
  rcs_sequencer #(.LOW_SUPPLY_CYCLES(20)) u_rcs_sequencer (
    .clk(clk), .rst(rst), .extRstNPin(extRstNPin),
    .lowSupplyRaw(lowSupplyRaw), .brownoutOption(brownoutOption),
    .wakeOption(wakeOption), .wdtOverflow(wdtOverflow),
    .haltExec(haltExec), .clrWdtExec(clrWdtExec), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .portAPinIn(portAPinIn), .portAPinOut(portAPinOut),
    .portAPinOeN(portAPinOeN), .portBPinIn(portBPinIn),
    .portBPinOut(portBPinOut), .portBPinOeN(portBPinOeN),
    .coreRst(coreRst), .coreStall(coreStall), .pcLoad(pcLoad),
    .pcInit(pcInit), .prescalerClr(prescalerClr),
    .watchdogSelect(watchdogSelect),
    .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag));
  rcs_far_side u_rcs_far_side (.clk(clk), .extRstNPin(extRstNPin),
    .lowSupplyRaw(lowSupplyRaw), .wdtOverflow(wdtOverflow));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========
  // Shared tasks
  task chk(input [7:0] seen, input [7:0] exp);
    nTests = nTests + 1;
    if (seen !== exp) begin
      numErrors = numErrors + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    @(posedge clk);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // Halt when isHalt, watchdog clear otherwise; flags settle by the edge
  task op(input isHalt);
    @(posedge clk);
    haltExec   <= isHalt;
    clrWdtExec <= !isHalt;
    @(posedge clk);
    haltExec   <= 1'b0;
    clrWdtExec <= 1'b0;
    #1;
  endtask
  // Stall length judged by window, sync latency makes it a few over 1024
  task delayOk(input exp);
    nStall = 0;
    sawRst = 1'b0;
    while (coreStall !== 1'b0 && nStall < 3000) begin
      @(posedge clk);
      #1 nStall = nStall + 1;
      sawRst = sawRst | coreRst;
    end
    chk({7'h00, nStall >= 1024 && nStall <= 1032}, {7'h00, exp});
  endtask
  function [7:0] fl(input t, input p);
    fl = {6'h00, t, p};
  endfunction

  // ==========
  // Scenarios
  task tPower;
    chk(fl(timeoutFlag, powerdownFlag), 8'h00);
    chk(portAPinOeN, 8'hff);
    chk({5'h00, portBPinOeN}, 8'h07);
    chk(portAPinOut, 8'hff);
    chk({5'h00, portBPinOut}, 8'h07);
    chk({6'h00, pcLoad, prescalerClr}, 8'h03);
    chk(pcInit[7:0] | {6'h00, pcInit[9:8]}, 8'h00);
    delayOk(1'b1);
    rd(`RCS_OFF_WDT_SELECT, 8'h07);
    rd(`RCS_OFF_PORTA_DATA, 8'hff);
    rd(`RCS_OFF_PORTA_DIR, 8'hff);
    rd(`RCS_OFF_PORTB_DIR, 8'h07);
    rd(`RCS_OFF_PORTB_DATA, 8'h05);
    rd(4'hf, 8'h00);
    wr(`RCS_OFF_STATUS, 8'hff);
    rd(`RCS_OFF_STATUS, 8'h00);
  endtask
  task tWdtRun;
    wr(`RCS_OFF_WDT_SELECT, 8'h55);
    wr(`RCS_OFF_PORTA_DIR, 8'h00);
    wr(`RCS_OFF_WORK_REG, 8'h3c);
    u_rcs_far_side.wdtPulse;
    #1 chk({7'h00, coreRst}, 8'h01);
    delayOk(1'b0);
    chk(fl(timeoutFlag, powerdownFlag), 8'h02);
    rd(`RCS_OFF_WDT_SELECT, 8'h07);
    rd(`RCS_OFF_PORTA_DIR, 8'hff);
    rd(`RCS_OFF_WORK_REG, 8'h3c);
  endtask
  task tPinRun;
    wr(`RCS_OFF_WDT_SELECT, 8'h55);
    u_rcs_far_side.pinLow(10);
    delayOk(1'b0);
    chk({7'h00, sawRst}, 8'h01);
    chk(fl(timeoutFlag, powerdownFlag), 8'h02);
    rd(`RCS_OFF_WDT_SELECT, 8'h07);
    op(1'b0);
    chk(fl(timeoutFlag, powerdownFlag), 8'h00);
  endtask
  task tHaltWdt;
    wr(`RCS_OFF_WDT_SELECT, 8'h5a);
    op(1'b1);
    chk(fl(timeoutFlag, powerdownFlag), 8'h01);
    u_rcs_far_side.wdtPulse;
    delayOk(1'b1);
    chk({7'h00, sawRst}, 8'h00);
    chk(fl(timeoutFlag, powerdownFlag), 8'h03);
    rd(`RCS_OFF_WDT_SELECT, 8'h5a);
  endtask
  task tPinHalt;
    op(1'b1);
    u_rcs_far_side.pinLow(10);
    delayOk(1'b1);
    chk(fl(timeoutFlag, powerdownFlag), 8'h01);
    rd(`RCS_OFF_WDT_SELECT, 8'h07);
  endtask
  task tWake;
    op(1'b1);
    @(posedge clk);
    portAPinIn <= 8'hfd;
    repeat (20) @(posedge clk);
    rd(`RCS_OFF_STATUS, 8'h11);
    @(posedge clk);
    portAPinIn <= 8'hfc;
    delayOk(1'b1);
    chk({7'h00, sawRst}, 8'h00);
    @(posedge clk);
    portAPinIn <= 8'hff;
  endtask
  task tBrown;
    u_rcs_far_side.supplyLow(10);
    repeat (5) @(posedge clk);
    #1 chk({7'h00, coreRst}, 8'h00);
    u_rcs_far_side.supplyLow(60);
    #1 chk({7'h00, coreRst}, 8'h01);
    delayOk(1'b1);
    chk(fl(timeoutFlag, powerdownFlag), 8'h00);
    @(posedge clk);
    brownoutOption <= 1'b0;
    u_rcs_far_side.supplyLow(60);
    #1 chk({7'h00, coreRst}, 8'h00);
  endtask

  // ==========
  // Verdict and run control
  task endOfTest;
    $display("errors %0d checks %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, about nine times the expected run
  initial begin
    #200000;
    numErrors = numErrors + 1;
    endOfTest;
  end
  // Main sequence; port B pads show 5, wake enabled on line 0 only
  initial begin
    numErrors      = 0;
    nTests         = 0;
    rst            = 1'b1;
    brownoutOption = 1'b1;
    wakeOption     = 8'h01;
    haltExec       = 1'b0;
    clrWdtExec     = 1'b0;
    regWrStrobe    = 1'b0;
    regRdStrobe    = 1'b0;
    regAddr        = 4'h0;
    regWrData      = 8'h00;
    portAPinIn     = 8'hff;
    portBPinIn     = 3'h5;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tPower;
    tWdtRun;
    tPinRun;
    tHaltWdt;
    tPinHalt;
    tWake;
    tBrown;
    endOfTest;
  end
endmodule // tb

// file: verilog/rcs_low_supply_filter.v
// Low-supply indication synchroniser and persistence filter
`timescale 1ns/1ps
`include "rcs_regs.vh"

module rcs_low_supply_filter #(
  parameter LOW_SUPPLY_CYCLES = `RCS_LOW_SUPPLY_CYC
) (
  input  wire clk,
  input  wire rst,
  input  wire lowSupplyRaw,
  input  wire filterEnable,
  output reg  brownoutRst
);

  // ========================================================
  // Synchroniser
  reg                      lowSync1Reg;
  reg                      lowSync2Reg;
  reg [`RCS_LOW_CNT_W-1:0] lowCntReg;

  // Two stages; only the second one is looked at
  always @(posedge clk) begin
    if (rst) begin
      lowSync1Reg <= 1'b0;
      lowSync2Reg <= 1'b0;
    end else begin
      lowSync1Reg <= lowSupplyRaw;
      lowSync2Reg <= lowSync1Reg;
    end
  end

  // ========================================================
  // Persistence counter
  // longer than one millisecond
  always @(posedge clk) begin
    if (rst || !filterEnable || !lowSync2Reg) begin
      lowCntReg   <= {`RCS_LOW_CNT_W{1'b0}};
      brownoutRst <= 1'b0;
    end else if (lowCntReg == LOW_SUPPLY_CYCLES[`RCS_LOW_CNT_W-1:0]) begin
      // Saturate; stays asserted while the supply stays low
      brownoutRst <= 1'b1;
    end else begin
      lowCntReg <= lowCntReg + {{(`RCS_LOW_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // rcs_low_supply_filter

// file: verilog/rcs_regs.vh
// Constants for the reset cause and start-up sequencer
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

// ==========================================================
// Register offsets (word index on the register port)
`define RCS_ADDR_W          4
`define RCS_OFF_WDT_SELECT  4'h0
`define RCS_OFF_PORTA_DATA  4'h1
`define RCS_OFF_PORTA_DIR   4'h2
`define RCS_OFF_PORTB_DATA  4'h3
`define RCS_OFF_PORTB_DIR   4'h4
`define RCS_OFF_MEM_PTR     4'h5
`define RCS_OFF_WORK_REG    4'h6
`define RCS_OFF_TABLE_PTR   4'h7
`define RCS_OFF_TABLE_HIGH  4'h8
`define RCS_OFF_STATUS      4'h9

// ==========================================================
// Status field positions
`define RCS_ST_HALTED       0
`define RCS_ST_DELAY        1
`define RCS_ST_CORE_RST     2
`define RCS_ST_PDF          4
`define RCS_ST_TO           5

// ==========================================================
// Reset values
`define RCS_WDT_SELECT_RST  8'h07
`define RCS_PORTA_RST       8'hff
`define RCS_PORTB_RST       3'h7
`define RCS_PC_RST          10'h000

// ==========================================================
// Timing
`define RCS_CLK_PERIOD_PS   4000
`define RCS_STARTUP_CLOCKS  1024
`define RCS_LOW_SUPPLY_US   1000
`define RCS_LOW_SUPPLY_CYC  \
  ((`RCS_LOW_SUPPLY_US * 1000000) / `RCS_CLK_PERIOD_PS)
`define RCS_LOW_CNT_W       18

`endif

// file: verilog/rcs_sequencer.v
// Reset cause recording, start-up delay and reset values of core regs
//
// Notes on behaviour
// - Pin reset in run, pin reset in halt, watchdog overflow in run.
// - Power-up clears both flags; pin run keeps; pin wake gives 0,1.
// - Watchdog in run sets timeout only; watchdog wake leaves both 1.
// - 1024 clock start-up delay after power-up and every halt wake.
// - Pin reset from run skips delay; every halt wake applies it.
// - Any chip reset: PC 000, prescaler clear, ports input.
// - Chip resets load select 07, port A ff, port B 7; warm holds.
// - Pointer, working, table registers never initialised by reset.
// - Low supply resets only after persisting more than 1 ms.
// - Filtered low supply ORed with the pin form chip reset.
// - After low-supply reset ends, count 1024 clocks before running.
// - A fixed option disables the low-supply reset path entirely.
// - After chip reset port lines are released as inputs.
// - Each port A line is separately enabled as a wake source.
// - Watchdog overflow sets timeout; power-up and clear clear it.
// - Watchdog overflow in halt zeroes only PC and the prescaler.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "rcs_regs.vh"

module rcs_sequencer #(
  parameter LOW_SUPPLY_CYCLES = `RCS_LOW_SUPPLY_CYC
) (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   extRstNPin,
  input  wire                   lowSupplyRaw,
  input  wire                   brownoutOption,
  input  wire [7:0]             wakeOption,
  input  wire                   wdtOverflow,
  input  wire                   haltExec,
  input  wire                   clrWdtExec,
  input  wire [`RCS_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWrData,
  input  wire                   regWrStrobe,
  input  wire                   regRdStrobe,
  output reg  [7:0]             regRdData,
  input  wire [7:0]             portAPinIn,
  output wire [7:0]             portAPinOut,
  output wire [7:0]             portAPinOeN,
  input  wire [2:0]             portBPinIn,
  output wire [2:0]             portBPinOut,
  output wire [2:0]             portBPinOeN,
  output wire                   coreRst,
  output wire                   coreStall,
  output wire                   pcLoad,
  output wire [9:0]             pcInit,
  output wire                   prescalerClr,
  output wire [7:0]             watchdogSelect,
  output wire                   timeoutFlag,
  output wire                   powerdownFlag
);

  // ==========================================================
  // States
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_HALT  = 4'b0010;
  localparam [3:0] ST_RESET = 4'b0100;
  localparam [3:0] ST_DELAY = 4'b1000;
  localparam integer DELAY_LAST_INT = `RCS_STARTUP_CLOCKS - 1;
  localparam [10:0]  DELAY_LAST     = DELAY_LAST_INT[10:0];

  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [10:0] delayCnt_reg;
  reg [10:0] delayCnt_next;
  reg        coldDelay_reg;
  reg        coldDelay_next;
  reg        delayPend_reg;
  reg        delayPend_next;
  reg        timeout_reg;
  reg        timeout_next;
  reg        powerdown_reg;
  reg        powerdown_next;
  reg        warmPulse_reg;
  reg        warmPulse_next;
  reg        prescPulse_reg;
  reg        prescPulse_next;

  reg        pinSync1_reg;
  reg        pinSync2_reg;
  reg [7:0]  portASync1_reg;
  reg [7:0]  portASync2_reg;
  reg [7:0]  portAPrev_reg;
  reg [2:0]  portBSync1_reg;
  reg [2:0]  portBSync2_reg;

  reg [7:0]  wdtSelect_reg;
  reg [7:0]  portAData_reg;
  reg [7:0]  portADir_reg;
  reg [2:0]  portBData_reg;
  reg [2:0]  portBDir_reg;
  reg [6:0]  memPtr_reg;
  reg [7:0]  workReg_reg;
  reg [7:0]  tablePtr_reg;
  reg [5:0]  tableHigh_reg;

  wire       brownoutRst;
  wire       pinLow;
  wire       wakeFall;

  // ==========================================================
  // Input synchronisers
  // pin passes two stages
  always @(posedge clk) begin
    if (rst) begin
      pinSync1_reg   <= 1'b1;
      pinSync2_reg   <= 1'b1;
      portASync1_reg <= 8'hff;
      portASync2_reg <= 8'hff;
      portAPrev_reg  <= 8'hff;
      portBSync1_reg <= 3'h7;
      portBSync2_reg <= 3'h7;
    end else begin
      pinSync1_reg   <= extRstNPin;
      pinSync2_reg   <= pinSync1_reg;
      portASync1_reg <= portAPinIn;
      portASync2_reg <= portASync1_reg;
      portAPrev_reg  <= portASync2_reg;
      portBSync1_reg <= portBPinIn;
      portBSync2_reg <= portBSync1_reg;
    end
  end

  rcs_low_supply_filter #(
    .LOW_SUPPLY_CYCLES (LOW_SUPPLY_CYCLES)
  ) u_lowSupply (
    .clk          (clk),
    .rst          (rst),
    .lowSupplyRaw (lowSupplyRaw),
    .filterEnable (brownoutOption),
    .brownoutRst  (brownoutRst)
  );

  assign pinLow = ~pinSync2_reg;
  assign wakeFall = |(portAPrev_reg & ~portASync2_reg & wakeOption);

  // ==========================================================
  // Sequencer next state; supply beats pin beats watchdog beats wake
  always @* begin
    state_next      = state_reg;
    delayCnt_next   = delayCnt_reg;
    coldDelay_next  = coldDelay_reg;
    delayPend_next  = delayPend_reg;
    timeout_next    = timeout_reg;
    powerdown_next  = powerdown_reg;
    warmPulse_next  = 1'b0;
    prescPulse_next = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (brownoutRst) begin
          state_next     = ST_RESET;
          delayPend_next = 1'b1;
          timeout_next   = 1'b0;
          powerdown_next = 1'b0;
        end else if (pinLow) begin
          state_next     = ST_RESET;
          delayPend_next = 1'b0;
        end else if (wdtOverflow) begin
          state_next     = ST_RESET;
          delayPend_next = 1'b0;
          timeout_next   = 1'b1;
        end else if (haltExec) begin
          state_next      = ST_HALT;
          timeout_next    = 1'b0;
          powerdown_next  = 1'b1;
          prescPulse_next = 1'b1;
        end else if (clrWdtExec) begin
          timeout_next   = 1'b0;
          powerdown_next = 1'b0;
        end
      end
      ST_HALT: begin
        if (brownoutRst) begin
          state_next     = ST_RESET;
          delayPend_next = 1'b1;
          timeout_next   = 1'b0;
          powerdown_next = 1'b0;
        end else if (pinLow) begin
          state_next     = ST_RESET;
          delayPend_next = 1'b1;
          timeout_next   = 1'b0;
          powerdown_next = 1'b1;
        end else if (wdtOverflow) begin
          state_next      = ST_DELAY;
          delayCnt_next   = 11'h000;
          coldDelay_next  = 1'b0;
          timeout_next    = 1'b1;
          powerdown_next  = 1'b1;
          warmPulse_next  = 1'b1;
          prescPulse_next = 1'b1;
        end else if (wakeFall) begin
          state_next     = ST_DELAY;
          delayCnt_next  = 11'h000;
          coldDelay_next = 1'b0;
        end
      end
      ST_RESET: begin
        if (brownoutRst) begin
          delayPend_next = 1'b1;
        end else if (!pinLow) begin
          if (delayPend_reg) begin
            state_next     = ST_DELAY;
            delayCnt_next  = 11'h000;
            coldDelay_next = 1'b1;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_DELAY: begin
        if (brownoutRst) begin
          state_next     = ST_RESET;
          delayPend_next = 1'b1;
          timeout_next   = 1'b0;
          powerdown_next = 1'b0;
        end else if (pinLow) begin
          // Pin during a wake counts as pin while halted
          state_next     = ST_RESET;
          delayPend_next = 1'b1;
          if (!coldDelay_reg) begin
            timeout_next   = 1'b0;
            powerdown_next = 1'b1;
          end
        end else if (delayCnt_reg == DELAY_LAST) begin
          state_next = ST_RUN;
        end else begin
          delayCnt_next = delayCnt_reg + 11'h001;
        end
      end
      default: begin
        state_next     = ST_RESET;
        delayPend_next = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Sequencer registers; power-up starts a cold delay
  always @(posedge clk) begin
    if (rst) begin
      state_reg      <= ST_DELAY;
      delayCnt_reg   <= 11'h000;
      coldDelay_reg  <= 1'b1;
      delayPend_reg  <= 1'b1;
      timeout_reg    <= 1'b0;
      powerdown_reg  <= 1'b0;
      warmPulse_reg  <= 1'b0;
      prescPulse_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      delayCnt_reg   <= delayCnt_next;
      coldDelay_reg  <= coldDelay_next;
      delayPend_reg  <= delayPend_next;
      timeout_reg    <= timeout_next;
      powerdown_reg  <= powerdown_next;
      warmPulse_reg  <= warmPulse_next;
      prescPulse_reg <= prescPulse_next;
    end
  end

  assign coreRst   = state_reg[2] | (state_reg[3] & coldDelay_reg);
  assign coreStall = ~state_reg[0];
  assign pcLoad       = coreRst | warmPulse_reg;
  assign pcInit       = `RCS_PC_RST;
  assign prescalerClr = coreRst | prescPulse_reg;

  assign timeoutFlag    = timeout_reg;
  assign powerdownFlag  = powerdown_reg;
  assign watchdogSelect = wdtSelect_reg;

  // ==========================================================
  // Register file, resettable ones first; warm reset never enters the reset state
  always @(posedge clk) begin
    if (rst || coreRst) begin
      wdtSelect_reg <= `RCS_WDT_SELECT_RST;
      portAData_reg <= `RCS_PORTA_RST;
      portADir_reg  <= `RCS_PORTA_RST;
      portBData_reg <= `RCS_PORTB_RST;
      portBDir_reg  <= `RCS_PORTB_RST;
    end else if (regWrStrobe) begin
      case (regAddr)
        `RCS_OFF_WDT_SELECT: wdtSelect_reg <= regWrData;
        `RCS_OFF_PORTA_DATA: portAData_reg <= regWrData;
        `RCS_OFF_PORTA_DIR:  portADir_reg  <= regWrData;
        `RCS_OFF_PORTB_DATA: portBData_reg <= regWrData[2:0];
        `RCS_OFF_PORTB_DIR:  portBDir_reg  <= regWrData[2:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk) begin
    if (regWrStrobe) begin
      case (regAddr)
        `RCS_OFF_MEM_PTR:    memPtr_reg    <= regWrData[6:0];
        `RCS_OFF_WORK_REG:   workReg_reg   <= regWrData;
        `RCS_OFF_TABLE_PTR:  tablePtr_reg  <= regWrData;
        `RCS_OFF_TABLE_HIGH: tableHigh_reg <= regWrData[5:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Pads; enable low drives, direction 1 means input
  // reset releases lines
  assign portAPinOut = portAData_reg;
  assign portAPinOeN = portADir_reg;
  assign portBPinOut = portBData_reg;
  assign portBPinOeN = portBDir_reg;

  // ==========================================================
  // Read port; data valid the cycle after the strobe only
  always @(posedge clk) begin
    if (rst || !regRdStrobe) begin
      regRdData <= 8'h00;
    end else begin
      case (regAddr)
        `RCS_OFF_WDT_SELECT: regRdData <= wdtSelect_reg;
        // Input lines read the pad, outputs read the latch
        `RCS_OFF_PORTA_DATA: regRdData <= (portADir_reg & portASync2_reg)
                                        | (~portADir_reg & portAData_reg);
        `RCS_OFF_PORTA_DIR:  regRdData <= portADir_reg;
        `RCS_OFF_PORTB_DATA: regRdData <= {5'h00,
                                  (portBDir_reg & portBSync2_reg)
                                | (~portBDir_reg & portBData_reg)};
        `RCS_OFF_PORTB_DIR:  regRdData <= {5'h00, portBDir_reg};
        `RCS_OFF_MEM_PTR:    regRdData <= {1'b0, memPtr_reg};
        `RCS_OFF_WORK_REG:   regRdData <= workReg_reg;
        `RCS_OFF_TABLE_PTR:  regRdData <= tablePtr_reg;
        `RCS_OFF_TABLE_HIGH: regRdData <= {2'h0, tableHigh_reg};
        `RCS_OFF_STATUS:     regRdData <= {2'h0, timeout_reg, powerdown_reg,
                                           1'b0, coreRst, state_reg[3],
                                           state_reg[1]};
        default:             regRdData <= 8'h00;
      endcase
    end
  end

endmodule // rcs_sequencer
